/* logic/dep_defines.vh */
`ifndef DEP_DEFINES_VH
`define DEP_DEFINES_VH
// Control/status register layout
`define DEP_CSR_ADDR 8'h30
`define DEP_CSR_RESET 8'h00
`define DEP_CSR_PGM_BIT 0
`define DEP_CSR_LAT_BIT 1
// Row geometry
`define DEP_ROW_BYTES 32
`define DEP_COL_BITS 5
// Programming cycle time in microseconds, and clock in MHz
`define DEP_PROG_TIME_US 3000
`define DEP_CLK_MHZ 125
`define DEP_PROG_CYCLES (`DEP_PROG_TIME_US * `DEP_CLK_MHZ)
// Erased cell value
`define DEP_ERASED_BYTE 8'hff
`endif

/* logic/dep_row_latch.v */
`timescale 1ns/1ps
`include "dep_defines.vh"
// One byte of the row latch bank; repeated writes AND into the held value
module dep_row_latch (
    input wire clk,
    input wire arst_n,
    input wire wrEn,
    input wire clrEn,
    input wire [7:0] wrData,
    output wire [7:0] latchData,
    output wire latchValid
);
    reg [7:0] data_q;
    reg valid_q;

    // Clear wins over write; a second write over-programs by AND
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= 8'hff;
            valid_q <= 1'b0;
        end else if (clrEn) begin
            data_q <= 8'hff;
            valid_q <= 1'b0;
        end else if (wrEn) begin
            data_q <= valid_q ? (data_q & wrData) : wrData;
            valid_q <= 1'b1;
        end
    end

    assign latchData = data_q;
    assign latchValid = valid_q;
endmodule // dep_row_latch

/* logic/dep_cycle_timer.v */
`timescale 1ns/1ps
`include "dep_defines.vh"
// Counts the programming cycle; done pulses on the last count
module dep_cycle_timer #(
    parameter integer CYCLES = `DEP_PROG_CYCLES
) (
    input wire clk,
    input wire arst_n,
    input wire start,
    input wire abort,
    output wire busy,
    output wire done
);
    reg [31:0] count_q;
    reg busy_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (abort) begin
            count_q <= 32'h0;
            busy_q <= 1'b0;
        end else if (start && !busy_q) begin
            count_q <= 32'h1;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (count_q >= CYCLES) begin
                busy_q <= 1'b0;
                count_q <= 32'h0;
            end else begin
                count_q <= count_q + 32'h1;
            end
        end
    end

    assign busy = busy_q;
    assign done = busy_q && (count_q >= CYCLES) && !abort;
endmodule // dep_cycle_timer

/* logic/dep_eeprom_prog.v */
`timescale 1ns/1ps
`include "dep_defines.vh"
module dep_eeprom_prog #(
    parameter integer ADDR_BITS = 7,
    parameter integer PROG_CYCLES = `DEP_PROG_CYCLES,
    parameter integer ERASE_CYCLES = `DEP_PROG_CYCLES
) (
    input wire clk,
    input wire arst_n,
    input wire memRead,
    input wire memFetch,
    input wire memWrite,
    input wire [ADDR_BITS-1:0] memAddr,
    input wire [7:0] memWdata,
    output reg [7:0] memRdata,
    output wire memRdataOe,
    input wire csrWrite,
    input wire csrRead,
    input wire [7:0] csrWdata,
    output wire [7:0] csrRdata,
    input wire waitReq,
    input wire haltReq,
    output wire waitAck,
    output wire haltAck,
    input wire extAccess,
    input wire readoutProtectOption,
    input wire protectRemoveReq,
    output wire protectRemoveDone,
    output wire eraseProgMemReq,
    output wire rowUndefined,
    output wire progBusy
);
    localparam integer ROWS = (1 << ADDR_BITS) / `DEP_ROW_BYTES;
    localparam integer ROW_BITS = ADDR_BITS - `DEP_COL_BITS;
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_PROG = 4'h2;
    localparam [3:0] ST_ERASE = 4'h4;
    localparam [3:0] ST_HALT = 4'h8;

    reg [7:0] mem_q [0:(1 << ADDR_BITS)-1];
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg latchMode_q;
    reg progStart_q;
    reg [ROW_BITS-1:0] rowAddr_q;
    reg [ROW_BITS-1:0] eraseRow_q;
    reg undef_q;
    reg eraseDone_q;
    reg rdOe_q;
    reg [ROW_BITS-1:0] undefRow_q;
    wire [7:0] latchData [0:`DEP_ROW_BYTES-1];
    wire [`DEP_ROW_BYTES-1:0] latchValid;
    wire [`DEP_COL_BITS-1:0] col = memAddr[`DEP_COL_BITS-1:0];
    wire [ROW_BITS-1:0] row = memAddr[ADDR_BITS-1:`DEP_COL_BITS];
    wire progDone;
    wire timerBusy;
    wire eraseBusy;
    wire eraseEnd;
    wire setPgm;
    wire clrLat;
    wire clrPgm;
    wire latchWrite;
    wire latchClear;
    wire abortProg;
    integer i;

    // Protection blocks all CPU writes into the latch bank
    assign latchWrite = memWrite && latchMode_q && !progStart_q
        && !readoutProtectOption;
    // Protection must also keep the timer from starting on a refused write
    assign setPgm = csrWrite && csrWdata[`DEP_CSR_PGM_BIT] && latchMode_q && !progStart_q
        && state_q == ST_IDLE && !readoutProtectOption;
    // Latch mode may only fall by software when program-start is clear
    assign clrLat = csrWrite && !csrWdata[`DEP_CSR_LAT_BIT]
        && !csrWdata[`DEP_CSR_PGM_BIT] && !progStart_q
        && !readoutProtectOption;
    assign clrPgm = csrWrite && !csrWdata[`DEP_CSR_PGM_BIT] && progStart_q
        && state_q == ST_PROG;
    // Halt abandons the cycle; a software clear ends it too
    assign abortProg = (haltReq && state_q == ST_PROG) || clrPgm;
    assign latchClear = progDone || (latchMode_q && clrLat) || abortProg;

    // Row latch bank, one byte each
    genvar g;
    generate
        for (g = 0; g < `DEP_ROW_BYTES; g = g + 1) begin : gLatch
            dep_row_latch uLatch (
                .clk(clk),
                .arst_n(arst_n),
                .wrEn(latchWrite && col == g),
                .clrEn(latchClear),
                .wrData(memWdata),
                .latchData(latchData[g]),
                .latchValid(latchValid[g])
            );
        end
    endgenerate

    // Internally timed programming cycle
    dep_cycle_timer #(
        .CYCLES(PROG_CYCLES)
    ) uProgTimer (
        .clk(clk),
        .arst_n(arst_n),
        .start(setPgm),
        .abort(abortProg),
        .busy(timerBusy),
        .done(progDone)
    );

    // Timed bulk erase when protection is removed
    dep_cycle_timer #(
        .CYCLES(ERASE_CYCLES)
    ) uEraseTimer (
        .clk(clk),
        .arst_n(arst_n),
        .start(state_q == ST_IDLE && protectRemoveReq && readoutProtectOption),
        .abort(1'b0),
        .busy(eraseBusy),
        .done(eraseEnd)
    );

    // Sequencer: idle, programming, erasing, halted
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (haltReq)
                    state_d = ST_HALT;
                else if (setPgm)
                    state_d = ST_PROG;
                else if (protectRemoveReq && readoutProtectOption)
                    state_d = ST_ERASE;
            end
            ST_PROG: begin
                if (haltReq)
                    state_d = ST_HALT;
                else if (progDone || clrPgm)
                    state_d = ST_IDLE;
            end
            ST_ERASE: begin
                if (eraseEnd)
                    state_d = ST_IDLE;
            end
            ST_HALT: begin
                if (!haltReq)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // Control bits; hardware end-of-cycle clears both together
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            latchMode_q <= 1'b0;
            progStart_q <= 1'b0;
        end else if (progDone || abortProg) begin
            latchMode_q <= progDone ? 1'b0 : latchMode_q;
            progStart_q <= 1'b0;
        end else if (csrWrite && !readoutProtectOption) begin
            if (csrWdata[`DEP_CSR_LAT_BIT] && !progStart_q)
                latchMode_q <= 1'b1;
            else if (clrLat)
                latchMode_q <= 1'b0;
            if (setPgm)
                progStart_q <= 1'b1;
        end
    end

    // Row of the last latched write becomes the target
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            rowAddr_q <= {ROW_BITS{1'b0}};
        else if (latchWrite)
            rowAddr_q <= row;
    end

    // Erase walks one row per clock while the erase timer runs
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eraseRow_q <= {ROW_BITS{1'b0}};
            eraseDone_q <= 1'b0;
        end else begin
            eraseDone_q <= eraseEnd;
            if (state_q == ST_ERASE && eraseBusy)
                eraseRow_q <= eraseRow_q + {{(ROW_BITS-1){1'b0}}, 1'b1};
            else
                eraseRow_q <= {ROW_BITS{1'b0}};
        end
    end

    // Array write: commit valid latches at cycle end, or erase rows
    always @(posedge clk) begin
        if (progDone) begin
            for (i = 0; i < `DEP_ROW_BYTES; i = i + 1)
                if (latchValid[i])
                    mem_q[{rowAddr_q, i[`DEP_COL_BITS-1:0]}] <= latchData[i];
        end else if (state_q == ST_ERASE) begin
            for (i = 0; i < `DEP_ROW_BYTES; i = i + 1)
                mem_q[{eraseRow_q, i[`DEP_COL_BITS-1:0]}] <= `DEP_ERASED_BYTE;
        end
    end

    // Row integrity flag: set on a cycle interrupted by halt or software clear, cleared by reset or by a new start on the same row
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            undef_q <= 1'b0;
            undefRow_q <= {ROW_BITS{1'b0}};
        end else if (abortProg) begin
            undef_q <= 1'b1;
            undefRow_q <= rowAddr_q;
        end else if (setPgm && undefRow_q == rowAddr_q) begin
            undef_q <= 1'b0;
        end
    end

    // Read path never touches the latch bank; protected external reads blocked
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            memRdata <= 8'h00;
            rdOe_q <= 1'b0;
        end else begin
            rdOe_q <= (memRead || memFetch) && !latchMode_q
                && !(extAccess && readoutProtectOption);
            if ((memRead || memFetch) && !latchMode_q)
                memRdata <= mem_q[memAddr];
        end
    end

    assign memRdataOe = rdOe_q;
    assign csrRdata = {6'h00, latchMode_q, progStart_q};
    // Wait acknowledged only when no cycle runs
    assign waitAck = waitReq && state_q == ST_IDLE;
    assign haltAck = state_q == ST_HALT;
    assign protectRemoveDone = eraseDone_q;
    assign eraseProgMemReq = state_q == ST_ERASE;
    // Reset mid-cycle simply loses the cycle; array holds whatever it had
    assign rowUndefined = undef_q;
    assign progBusy = timerBusy;
endmodule // dep_eeprom_prog

/* tb/dep_eeprom_prog_properties.sv */
`timescale 1ns/1ps
// Port-level watch on the row programmer
module dep_prog_checker #(
    parameter integer PROG_CYCLES = 20
) (
    input wire clk,
    input wire arst_n,
    input wire memRead,
    input wire memFetch,
    input wire memRdataOe,
    input wire csrWrite,
    input wire [7:0] csrWdata,
    input wire [7:0] csrRdata,
    input wire waitReq,
    input wire haltReq,
    input wire waitAck,
    input wire haltAck,
    input wire readoutProtectOption,
    input wire extAccess,
    input wire progBusy
);
    // Slack of a few cycles for start and end handshakes
    localparam int MAXW = PROG_CYCLES + 4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_start;
        csrWrite && csrWdata[1:0] == 2'h3 && csrRdata[1] && !progBusy && !readoutProtectOption;
    endsequence
    a_resv_zero: assert property (csrRdata[7:2] == 6'h00)
        else $error("reserved control bits set");
    a_rom_read: assert property ((memRead || memFetch) && !csrRdata[1]
        && !(extAccess && readoutProtectOption) |=> memRdataOe)
        else $error("read mode read not driven");
    a_ext_block: assert property (memRead && extAccess && readoutProtectOption
        |=> !memRdataOe)
        else $error("protected external read drove bus");
    a_latch_noread: assert property (memRead && csrRdata[1] |=> !memRdataOe)
        else $error("latch mode read drove bus");
    a_start_busy: assert property (s_start |=> csrRdata[0] ##[0:1] progBusy)
        else $error("start bit not held at start");
    a_cycle_bound: assert property ($rose(progBusy) |-> ##[1:MAXW] !csrRdata[0])
        else $error("programming cycle never ended");
    a_clear_both: assert property ($fell(csrRdata[0]) && !$past(csrWrite) && !$past(haltReq)
        |-> !csrRdata[1])
        else $error("control bits did not clear together");
    a_latch_hold: assert property (csrRdata[0] && progBusy && csrWrite && !csrWdata[1]
        |=> csrRdata[1])
        else $error("latch mode cleared while started");
    a_wait_busy: assert property (waitReq && progBusy && csrRdata[0] |-> !waitAck)
        else $error("wait taken during cycle");
    a_wait_idle: assert property (waitReq && !progBusy && !csrRdata[0] && !haltAck
        |-> waitAck)
        else $error("wait refused while idle");
    a_halt_stop: assert property (haltReq && progBusy |-> ##[1:2] (haltAck && !progBusy))
        else $error("halt did not stop cycle");
    a_protect_csr: assert property (readoutProtectOption && csrWrite && !progBusy
        |=> $stable(csrRdata))
        else $error("control write under protection");
endmodule // dep_prog_checker

bind dep_eeprom_prog dep_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clk(clk),
    .arst_n(arst_n), .memRead(memRead), .memFetch(memFetch), .memRdataOe(memRdataOe),
    .csrWrite(csrWrite), .csrWdata(csrWdata), .csrRdata(csrRdata), .waitReq(waitReq),
    .haltReq(haltReq), .waitAck(waitAck), .haltAck(haltAck), .progBusy(progBusy),
    .readoutProtectOption(readoutProtectOption), .extAccess(extAccess));

/* tb/dep_cpu_model.sv */
`timescale 1ns/1ps
// CPU side: byte accesses launched at the falling edge
module dep_cpu_model (
    input wire clk,
    input wire [7:0] memRdata,
    input wire memRdataOe,
    output reg memRead,
    output reg memFetch,
    output reg memWrite,
    output reg [6:0] memAddr,
    output reg [7:0] memWdata,
    output reg csrWrite,
    output reg [7:0] csrWdata
);
    // Idle bus at time zero
    initial begin
        {memRead, memFetch, memWrite, csrWrite} = 4'h0;
        memAddr = 7'h00;
        memWdata = 8'h00;
        csrWdata = 8'h00;
    end
    // Released data is inverted so a stale value never looks valid
    task wr_csr(input [7:0] v);
        @(negedge clk) csrWrite = 1'b1;
        csrWdata = v;
        @(negedge clk) csrWrite = 1'b0;
        csrWdata = ~v;
    endtask
    // Caller keeps the row fixed between starts
    task wr_mem(input [6:0] a, input [7:0] d);
        @(negedge clk) memWrite = 1'b1;
        memAddr = a;
        memWdata = d;
        @(negedge clk) memWrite = 1'b0;
        memAddr = ~a;
        memWdata = ~d;
    endtask
    // Data and drive flag are taken one cycle after the strobe
    task rd_mem(input f, input [6:0] a, output [7:0] d, output oe);
        @(negedge clk) memRead = !f;
        memFetch = f;
        memAddr = a;
        @(negedge clk) {memRead, memFetch} = 2'h0;
        memAddr = ~a;
        d = memRdata;
        oe = memRdataOe;
    endtask
endmodule // dep_cpu_model

/* tb/dep_eeprom_prog_tb.sv */
`timescale 1ns/1ps
module dep_eeprom_prog_tb;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg waitReq = 1'b0;
    reg haltReq = 1'b0;
    reg prot = 1'b0;
    reg ext = 1'b0;
    reg prr = 1'b0;
    wire protDone, eraseReq;
    integer mismatches = 0;
    integer total_checks = 0;
    wire memRead, memFetch, memWrite, memRdataOe, csrWrite;
    wire waitAck, haltAck, rowUndefined, progBusy;
    wire [6:0] memAddr;
    wire [7:0] memWdata, memRdata, csrWdata, csrRdata;
    // 125 MHz
    always #4 clk = ~clk;
    dep_cpu_model cpu_u (.clk(clk), .memRdata(memRdata), .memRdataOe(memRdataOe),
        .memRead(memRead), .memFetch(memFetch), .memWrite(memWrite), .memAddr(memAddr),
        .memWdata(memWdata), .csrWrite(csrWrite), .csrWdata(csrWdata));
    // Short cycle keeps the run small
    dep_eeprom_prog #(.ADDR_BITS(7), .PROG_CYCLES(20), .ERASE_CYCLES(20)) dut_u (.clk(clk),
        .arst_n(arst_n), .memRead(memRead), .memFetch(memFetch), .memWrite(memWrite),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .memRdataOe(memRdataOe), .csrWrite(csrWrite), .csrRead(1'b0), .csrWdata(csrWdata),
        .csrRdata(csrRdata), .waitReq(waitReq), .haltReq(haltReq), .waitAck(waitAck),
        .haltAck(haltAck), .extAccess(ext), .readoutProtectOption(prot),
        .protectRemoveReq(prr), .protectRemoveDone(protDone), .eraseProgMemReq(eraseReq),
        .rowUndefined(rowUndefined), .progBusy(progBusy));
    task wrap_up;
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input [7:0] seen, input [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Read and compare the drive flag, and the data only when a drive is expected
    task rd_chk(input f, input [6:0] a, input oe_e, input [7:0] d_e);
        reg [7:0] d;
        reg oe;
        cpu_u.rd_mem(f, a, d, oe);
        chk({7'h00, oe}, {7'h00, oe_e});
        if (oe_e) chk(d, d_e);
    endtask
    // Bounded poll of the start bit
    task wait_idle;
        integer i;
        i = 0;
        while (csrRdata[0] !== 1'b0 && i < 60) begin
            @(negedge clk);
            i = i + 1;
        end
        if (i == 60) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    endtask
    task t_program;
        cpu_u.wr_csr(8'h02);
        chk(csrRdata, 8'h02);
        cpu_u.wr_mem(7'h25, 8'h5a);
        cpu_u.wr_mem(7'h25, 8'h0f);
        cpu_u.wr_mem(7'h3f, 8'hc3);
        cpu_u.wr_csr(8'h03);
        chk(csrRdata, 8'h03);
        rd_chk(1'b0, 7'h25, 1'b0, 8'h00);
        cpu_u.wr_csr(8'h01);
        chk(csrRdata, 8'h03);
        wait_idle;
        chk(csrRdata, 8'h00);
        rd_chk(1'b0, 7'h25, 1'b1, 8'h0a);
        rd_chk(1'b0, 7'h3f, 1'b1, 8'hc3);
    endtask
    task t_readmode;
        cpu_u.wr_mem(7'h25, 8'h00);
        rd_chk(1'b1, 7'h25, 1'b1, 8'h0a);
    endtask
    task t_latclear;
        cpu_u.wr_csr(8'h02);
        cpu_u.wr_mem(7'h25, 8'h00);
        cpu_u.wr_csr(8'h00);
        cpu_u.wr_csr(8'h02);
        cpu_u.wr_mem(7'h26, 8'h11);
        cpu_u.wr_csr(8'h03);
        wait_idle;
        rd_chk(1'b0, 7'h25, 1'b1, 8'h0a);
        rd_chk(1'b0, 7'h26, 1'b1, 8'h11);
    endtask
    task t_wait;
        cpu_u.wr_csr(8'h02);
        cpu_u.wr_mem(7'h41, 8'h33);
        cpu_u.wr_csr(8'h03);
        waitReq = 1'b1;
        @(negedge clk);
        chk({7'h00, waitAck}, 8'h00);
        wait_idle;
        @(negedge clk);
        chk({7'h00, waitAck}, 8'h01);
        waitReq = 1'b0;
        rd_chk(1'b0, 7'h41, 1'b1, 8'h33);
    endtask
    task t_halt;
        cpu_u.wr_csr(8'h02);
        cpu_u.wr_mem(7'h42, 8'h44);
        cpu_u.wr_csr(8'h03);
        repeat (3) @(negedge clk);
        haltReq = 1'b1;
        repeat (3) @(negedge clk);
        chk({5'h00, haltAck, progBusy, rowUndefined}, 8'h05);
        haltReq = 1'b0;
        cpu_u.wr_csr(8'h00);
        chk(csrRdata, 8'h00);
    endtask
    // Protection: refused writes, blocked outside reads, erase on removal
    task t_protect;
        integer i;
        prot = 1'b1;
        cpu_u.wr_csr(8'h02);
        chk(csrRdata, 8'h00);
        ext = 1'b1;
        rd_chk(1'b0, 7'h25, 1'b0, 8'h00);
        ext = 1'b0;
        rd_chk(1'b0, 7'h25, 1'b1, 8'h0a);
        prr = 1'b1;
        @(negedge clk);
        prr = 1'b0;
        chk({7'h00, eraseReq}, 8'h01);
        i = 0;
        while (protDone !== 1'b1 && i < 40) begin
            @(negedge clk);
            i = i + 1;
        end
        chk({7'h00, protDone}, 8'h01);
        rd_chk(1'b0, 7'h25, 1'b1, 8'hff);
        prot = 1'b0;
    endtask
    // Reset in mid-cycle drops the cycle and both control bits
    task t_reset;
        cpu_u.wr_csr(8'h02);
        cpu_u.wr_mem(7'h60, 8'h77);
        cpu_u.wr_csr(8'h03);
        repeat (3) @(negedge clk);
        chk({7'h00, progBusy}, 8'h01);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk(csrRdata, 8'h00);
        chk({7'h00, progBusy}, 8'h00);
    endtask
    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        @(negedge clk);
        chk(csrRdata, 8'h00);
        t_program;
        t_readmode;
        t_latclear;
        t_wait;
        t_halt;
        t_protect;
        t_reset;
        wrap_up;
    end
endmodule // dep_eeprom_prog_tb
